// file: refl_pkg.sv
package refl_pkg;
  // register indices (printed offsets are not word aligned, byte address = 4 * index)
  localparam logic [15:0] IDX_AMP_C_PAIR0 = 16'h019F;
  localparam logic [15:0] IDX_AMP_C_PAIR1 = 16'h01A0;
  localparam logic [15:0] IDX_AMP_CD_PAIR = 16'h01A1;
  localparam logic [15:0] IDX_AMP_D_PAIR0 = 16'h01A2;
  localparam logic [15:0] IDX_AMP_D_PAIR1 = 16'h01A3;
  localparam logic [15:0] IDX_STATUS = 16'h01A4;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'h01A5;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h01A6;
  // field positions
  localparam int AMP_HI_LSB = 8;
  localparam int AMP_LO_LSB = 0;
  localparam int AMP_W = 7;
  localparam int CROSS_D_BIT = 11;
  localparam int CROSS_C_BIT = 10;
  localparam int CROSS_B_BIT = 9;
  localparam int CROSS_A_BIT = 8;
  localparam int OVF_D_BIT = 7;
  localparam int OVF_C_BIT = 6;
  localparam int OVF_B_BIT = 5;
  localparam int OVF_A_BIT = 4;
  // interrupt event bits
  localparam int EVT_DONE_BIT = 0;
  localparam int EVT_CROSS_BIT = 1;
  localparam int EVT_OVF_BIT = 2;
  localparam int EVT_W = 3;
  // reset values
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [6:0] AMP_RESET = 7'h00;
  localparam logic [2:0] EVT_RESET = 3'h0;
  localparam logic [3:0] FLAG_RESET = 4'h0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  // apb slave states
  typedef enum logic [0:0] {
    APB_IDLE = 1'b0,
    APB_ACK = 1'b1
  } apb_state_t;
endpackage

// file: refl_amp_pack.sv
`timescale 1ns/10ps
module refl_amp_pack (
  // two amplitude fields
  input wire logic [6:0] amp_hi,
  input wire logic [6:0] amp_lo,
  // packed word
  output logic [15:0] word
);
  // reserved bits 15 and 7 forced to zero
  assign word = {1'b0, amp_hi, 1'b0, amp_lo};
endmodule

// file: refl_results.sv
// Register access over APB was decided locally.
`timescale 1ns/10ps
// Overview of operation
// - each peak amplitude is a 7-bit read-only field at 14:8 or 6:0; bits 15 and 7 read zero.
// - amplitudes pack as C1/C0, C3/C2, D0/C4, D2/D1, D4/D3 in the five consecutive words.
// - every amplitude field and status bit resets to zero and cannot be written.
// - status bits 11, 10, 9 flag cross reflection on channels D, C, B; bits 15:12 read zero.
// - the channel A cross-reflection flag sits at status bit 8.
// - status bits 7, 6, 5, 4 flag more than five reflections on D, C, B, A; bits 3:0 read zero.
// - a clear cross flag means no cross reflection, a clear overflow flag means normal operation.
module refl_results (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // results from the measurement engine
  input wire logic run_done,
  input wire logic [34:0] amp_c,
  input wire logic [34:0] amp_d,
  input wire logic [3:0] cross_flags,
  input wire logic [3:0] ovf_flags,
  // interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // result store

  logic [6:0] amp_c_q [5];
  logic [6:0] amp_d_q [5];
  logic [3:0] cross_q;
  logic [3:0] ovf_q;

  // pick field n of a flat engine bus
  function automatic logic [6:0] field(input logic [34:0] bus, input int n);
    field = bus[n*7 +: 7];
  endfunction

  // load only on run completion, otherwise hold
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < 5; i++) begin
        amp_c_q[i] <= refl_pkg::AMP_RESET;
        amp_d_q[i] <= refl_pkg::AMP_RESET;
      end
    end else if (run_done) begin
      for (int i = 0; i < 5; i++) begin
        amp_c_q[i] <= field(amp_c, i);
        amp_d_q[i] <= field(amp_d, i);
      end
    end
  end

  // flags replaced whole per run, so a clean run clears old faults
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cross_q <= refl_pkg::FLAG_RESET;
      ovf_q <= refl_pkg::FLAG_RESET;
    end else if (run_done) begin
      cross_q <= cross_flags;
      ovf_q <= ovf_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // word packing

  logic [15:0] word_c0, word_c1, word_cd, word_d0, word_d1, status_word;

  refl_amp_pack u_pack_c0 (.amp_hi(amp_c_q[1]), .amp_lo(amp_c_q[0]), .word(word_c0));
  refl_amp_pack u_pack_c1 (.amp_hi(amp_c_q[3]), .amp_lo(amp_c_q[2]), .word(word_c1));
  refl_amp_pack u_pack_cd (.amp_hi(amp_d_q[0]), .amp_lo(amp_c_q[4]), .word(word_cd));
  refl_amp_pack u_pack_d0 (.amp_hi(amp_d_q[2]), .amp_lo(amp_d_q[1]), .word(word_d0));
  refl_amp_pack u_pack_d1 (.amp_hi(amp_d_q[4]), .amp_lo(amp_d_q[3]), .word(word_d1));

  // status layout, reserved bits stay zero
  always_comb begin
    status_word = refl_pkg::REG_RESET;
    status_word[refl_pkg::CROSS_D_BIT] = cross_q[3];
    status_word[refl_pkg::CROSS_C_BIT] = cross_q[2];
    status_word[refl_pkg::CROSS_B_BIT] = cross_q[1];
    status_word[refl_pkg::CROSS_A_BIT] = cross_q[0];
    status_word[refl_pkg::OVF_D_BIT] = ovf_q[3];
    status_word[refl_pkg::OVF_C_BIT] = ovf_q[2];
    status_word[refl_pkg::OVF_B_BIT] = ovf_q[1];
    status_word[refl_pkg::OVF_A_BIT] = ovf_q[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: no wait states, read data registered

  refl_pkg::apb_state_t apb_q;
  logic [15:0] idx;
  logic setup;
  logic rd_irq_st;
  logic [2:0] irq_st_q;
  logic [2:0] irq_mask_q;
  logic [31:0] rdata_d;
  logic err_d;

  assign idx = paddr[17:2];
  assign setup = psel && !penable;
  // the status read clears at the completing edge
  assign rd_irq_st = psel && penable && pready && !pwrite && (idx == refl_pkg::IDX_IRQ_STATUS);

  // ready in the access phase after the data register has loaded
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      apb_q <= refl_pkg::APB_IDLE;
    end else begin
      case (apb_q)
        refl_pkg::APB_IDLE: apb_q <= setup ? refl_pkg::APB_ACK : refl_pkg::APB_IDLE;
        refl_pkg::APB_ACK: apb_q <= refl_pkg::APB_IDLE;
        default: apb_q <= refl_pkg::APB_IDLE;
      endcase
    end
  end
  assign pready = (apb_q == refl_pkg::APB_ACK) && psel && penable;

  // read mux; result words refuse writes, which is the only way to flag it
  always_comb begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    case (idx)
      refl_pkg::IDX_AMP_C_PAIR0: rdata_d[15:0] = word_c0;
      refl_pkg::IDX_AMP_C_PAIR1: rdata_d[15:0] = word_c1;
      refl_pkg::IDX_AMP_CD_PAIR: rdata_d[15:0] = word_cd;
      refl_pkg::IDX_AMP_D_PAIR0: rdata_d[15:0] = word_d0;
      refl_pkg::IDX_AMP_D_PAIR1: rdata_d[15:0] = word_d1;
      refl_pkg::IDX_STATUS: rdata_d[15:0] = status_word;
      refl_pkg::IDX_IRQ_STATUS: rdata_d[2:0] = irq_st_q;
      refl_pkg::IDX_IRQ_MASK: rdata_d[2:0] = irq_mask_q;
      default: err_d = 1'b1;
    endcase
    if (pwrite && idx != refl_pkg::IDX_IRQ_MASK && idx != refl_pkg::IDX_IRQ_STATUS) begin
      err_d = 1'b1;
    end
  end

  // capture answer during setup
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prdata <= refl_pkg::RDATA_RESET;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rdata_d;
      pslverr <= err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  logic [2:0] evt;
  assign evt = {run_done && |ovf_flags, run_done && |cross_flags, run_done};

  // mask register is the only writable word
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_mask_q <= refl_pkg::EVT_RESET;
    end else if (psel && penable && pready && pwrite && idx == refl_pkg::IDX_IRQ_MASK) begin
      irq_mask_q <= pwdata[2:0];
    end
  end

  // sticky events; the clear takes only the bits the read reported, since an event
  // landing on the setup edge is missing from the captured word and must survive
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_st_q <= refl_pkg::EVT_RESET;
    end else begin
      irq_st_q <= (rd_irq_st ? (irq_st_q & ~prdata[2:0]) : irq_st_q) | evt;
    end
  end

  assign irq = |(irq_st_q & irq_mask_q);

endmodule

// file: refl_results_assertions.sv
`timescale 1ns/10ps
module refl_results_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // engine and interrupt
  input wire logic run_done,
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // index of the word being accessed
  wire logic [15:0] idx = paddr[17:2];
  wire logic rd_done = pready && !pwrite;
  wire logic amp_hit = idx >= refl_pkg::IDX_AMP_C_PAIR0 && idx <= refl_pkg::IDX_AMP_D_PAIR1;
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_amp_reserved: assert property (rd_done && amp_hit |-> !prdata[15] && !prdata[7])
    else $error("amplitude reserved bit set");
  a_status_reserved: assert property (rd_done && idx == refl_pkg::IDX_STATUS |->
    prdata[15:12] == 4'h0 && prdata[3:0] == 4'h0) else $error("status reserved bits set");
  a_write_refused: assert property (pready && pwrite && (amp_hit ||
    idx == refl_pkg::IDX_STATUS) |-> pslverr) else $error("result write accepted");
  a_unmapped_err: assert property (rd_done && idx > refl_pkg::IDX_IRQ_MASK |->
    pslverr && prdata == 32'h00000000) else $error("unmapped read not refused");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !irq && !pready && prdata == 0)
    else $error("outputs not cleared by reset");
  a_irq_cause: assert property ($rose(irq) |-> $past(run_done) || $past(pwrite && pready))
    else $error("interrupt rose without cause");
  a_irq_fall: assert property ($fell(irq) |-> $past(pready) || $past(sys_rst))
    else $error("interrupt fell without access");
endmodule

// file: tb.sv
`timescale 1ns/10ps
module tb;
  logic mclk, sys_rst, psel, penable, pwrite, run_done, pready, pslverr, irq, er;
  logic [31:0] paddr, pwdata, prdata, rd, msk, st_exp;
  logic [34:0] amp_c, amp_d, ac, ad;
  logic [3:0] cross_flags, ovf_flags;
  logic [6:0] c [5];
  logic [6:0] d [5];
  int mismatches, check_count;
  refl_results dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .run_done(run_done), .amp_c(amp_c), .amp_d(amp_d),
    .cross_flags(cross_flags), .ovf_flags(ovf_flags), .irq(irq));
  // free-running 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one apb transfer; waits for pready, never a fixed count
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {14'h0000, idx, 2'h0};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task automatic rchk(input logic [15:0] idx, input logic [31:0] exp, input logic eer);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
    chk({31'h0, er}, {31'h0, eer});
  endtask
  ////////////////////////////////////////
  // four runs walking each channel flag, then an all-clear run
  initial begin
    {sys_rst, psel, penable, pwrite, run_done} = 5'h10;
    {paddr, pwdata, amp_c, amp_d, cross_flags, ovf_flags} = '0;
    mismatches = 0;
    check_count = 0;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) rchk(refl_pkg::IDX_AMP_C_PAIR0 + 16'(i), 32'h0, 1'b0);
    apb(1'b1, refl_pkg::IDX_STATUS, 32'hFFFF);
    chk({31'h0, er}, 32'h1);
    // a write to the event word is ignored without an error
    apb(1'b1, refl_pkg::IDX_IRQ_STATUS, 32'h7);
    chk({31'h0, er}, 32'h0);
    rchk(refl_pkg::IDX_IRQ_STATUS, 32'h0, 1'b0);
    rchk(refl_pkg::IDX_IRQ_MASK + 16'h1, 32'h0, 1'b1);
    for (int k = 0; k < 5; k++) begin
      // no mask bit on the first run, then one per run; last run sets the cross and overflow bits only, masking out the lone done event
      msk = (k == 0) ? 32'h0 : (k == 4) ? 32'h6 : 32'(1 << (k - 1));
      apb(1'b1, refl_pkg::IDX_IRQ_MASK, msk);
      chk({31'h0, er}, 32'h0);
      rchk(refl_pkg::IDX_IRQ_MASK, msk, 1'b0);
      for (int n = 0; n < 5; n++) begin
        c[n] = 7'(k * 37 + n * 19 + 64);
        d[n] = 7'(~(k * 23 + n * 11));
        ac[7*n +: 7] = c[n];
        ad[7*n +: 7] = d[n];
      end
      @(posedge mclk);
      run_done <= 1'b1;
      amp_c <= ac;
      amp_d <= ad;
      cross_flags <= (k < 4) ? 4'(1 << k) : 4'h0;
      ovf_flags <= (k < 4) ? 4'(8 >> k) : 4'h0;
      @(posedge mclk);
      // inputs move after the load so stale holding shows up
      run_done <= 1'b0;
      {amp_c, amp_d, cross_flags, ovf_flags} <= {~ac, ~ad, 8'hFF};
      @(posedge mclk);
      chk({31'h0, irq}, {31'h0, k != 0 && k != 4});
      rchk(refl_pkg::IDX_AMP_C_PAIR0, {17'h0, c[1], 1'b0, c[0]}, 1'b0);
      rchk(refl_pkg::IDX_AMP_C_PAIR1, {17'h0, c[3], 1'b0, c[2]}, 1'b0);
      rchk(refl_pkg::IDX_AMP_CD_PAIR, {17'h0, d[0], 1'b0, c[4]}, 1'b0);
      rchk(refl_pkg::IDX_AMP_D_PAIR0, {17'h0, d[2], 1'b0, d[1]}, 1'b0);
      rchk(refl_pkg::IDX_AMP_D_PAIR1, {17'h0, d[4], 1'b0, d[3]}, 1'b0);
      st_exp = (k < 4) ? 32'((1 << (8 + k)) | (1 << (7 - k))) : 32'h0;
      rchk(refl_pkg::IDX_STATUS, st_exp, 1'b0);
      rchk(refl_pkg::IDX_IRQ_STATUS, (k < 4) ? 32'h7 : 32'h1, 1'b0);
      @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
    end
    // reset after the last run must wipe the last results and the mask
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rchk(refl_pkg::IDX_AMP_CD_PAIR, 32'h0, 1'b0);
    rchk(refl_pkg::IDX_IRQ_MASK, 32'h0, 1'b0);
    tally_and_finish();
  end
endmodule
bind refl_results refl_results_chk chk_i (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .run_done(run_done), .irq(irq));
